// ---- logic/civ_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module civ_ctrl (
	clk,
	rst_n,
	pin_irq_line_0,
	pin_irq_line_1,
	pin_irq_line_2,
	pin_irq_line_3,
	per_flag,
	per_enable,
	per_flag_clear,
	sens_wr,
	sens_wdata,
	instr_done,
	trap_exec,
	return_from_handler,
	wait_exec,
	halt_exec,
	cpu_pc,
	cpu_x,
	cpu_a,
	condition_flags_reg,
	stack_rdata,
	mask_flag,
	sens_cfg,
	stack_we,
	stack_re,
	stack_addr,
	stack_wdata,
	pc_load,
	pc_value,
	restore_valid,
	restore_x,
	restore_a,
	restore_cc,
	cpu_stall,
	wake,
	ack_src
);
	input  wire logic        clk;
	input  wire logic        rst_n;
	input  wire logic        pin_irq_line_0;
	input  wire logic        pin_irq_line_1;
	input  wire logic        pin_irq_line_2;
	input  wire logic        pin_irq_line_3;
	input  wire logic [5:0]  per_flag;
	input  wire logic [5:0]  per_enable;
	input  wire logic [5:0]  per_flag_clear;
	input  wire logic        sens_wr;
	input  wire logic [7:0]  sens_wdata;
	input  wire logic        instr_done;
	input  wire logic        trap_exec;
	input  wire logic        return_from_handler;
	input  wire logic        wait_exec;
	input  wire logic        halt_exec;
	input  wire logic [15:0] cpu_pc;
	input  wire logic [7:0]  cpu_x;
	input  wire logic [7:0]  cpu_a;
	input  wire logic [7:0]  condition_flags_reg;
	input  wire logic [7:0]  stack_rdata;
	output logic             mask_flag;
	output logic [7:0]       sens_cfg;
	output logic             stack_we;
	output logic             stack_re;
	output logic [7:0]       stack_addr;
	output logic [7:0]       stack_wdata;
	output logic             pc_load;
	output logic [15:0]      pc_value;
	output logic             restore_valid;
	output logic [7:0]       restore_x;
	output logic [7:0]       restore_a;
	output logic [7:0]       restore_cc;
	output logic             cpu_stall;
	output logic             wake;
	output logic [9:0]       ack_src;

	civ_pkg::civ_state_t state_ff, nxt_state;
	logic [3:0]  pins_sync;
	logic [3:0]  ext_pend;
	logic [5:0]  per_latch_ff;
	logic [2:0]  cnt_ff;
	logic [7:0]  sp_ff;
	logic [3:0]  vec_ff;
	logic        trap_ff;
	logic [15:0] pc_save_ff;
	logic [7:0]  x_save_ff;
	logic [7:0]  a_save_ff;
	logic [7:0]  cc_save_ff;
	logic [15:0] ret_pc_ff;
	logic [3:0]  ext_ack;

	wire [3:0] pins_raw = {pin_irq_line_3, pin_irq_line_2, pin_irq_line_1, pin_irq_line_0};
	genvar gi;
	generate
		for (gi = 0; gi < civ_pkg::NUM_EXT; gi++) begin : g_ext
			civ_sync u_sync (
				.clk   (clk),
				.rst_n (rst_n),
				.d     (pins_raw[gi]),
				.q     (pins_sync[gi])
			);
			civ_ext_line u_line (
				.clk         (clk),
				.rst_n       (rst_n),
				.pin_sync    (pins_sync[gi]),
				.sens        (sens_cfg[2*gi+1:2*gi]),
				.sens_change (sens_wr & mask_flag &
				              (sens_wdata[2*gi+1:2*gi] != sens_cfg[2*gi+1:2*gi])),
				.ack         (ext_ack[gi]),
				.pending     (ext_pend[gi])
			);
		end
	endgenerate

	wire [5:0] per_req  = per_latch_ff & per_enable;
	wire [9:0] src_pend = {per_req, ext_pend};
	logic [3:0] sel_idx;
	logic       sel_any;
	always_comb begin
		sel_idx = 4'h0;
		sel_any = 1'b0;
		for (int i = civ_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (src_pend[i]) begin
				sel_idx = 4'(i);
				sel_any = 1'b1;
			end
		end
	end
	wire [3:0] sel_vec = (sel_idx < 4'(civ_pkg::NUM_EXT)) ?
	                     civ_pkg::SRC_EXT0 + sel_idx :
	                     civ_pkg::SRC_PER0 + sel_idx - 4'(civ_pkg::NUM_EXT);
	wire take_trap = instr_done & trap_exec & (state_ff == civ_pkg::CIV_RUN);
	wire take_irq  = instr_done & ~mask_flag & sel_any & ~trap_exec &
	                 (state_ff == civ_pkg::CIV_RUN);
	wire wake_wait = (state_ff == civ_pkg::CIV_WAIT) & (|src_pend);
	wire wake_halt = (state_ff == civ_pkg::CIV_HALT) &
	                 (|(src_pend & civ_pkg::HALT_WAKE_MASK));
	wire low_wake  = wake_wait | wake_halt;
	wire take_low  = low_wake & ~mask_flag & sel_any;
	wire enter     = take_trap | take_irq | take_low;
	wire [15:0] vec_addr = trap_ff ? civ_pkg::VEC_TRAP :
	                       civ_pkg::VEC_BASE - {11'h000, vec_ff, 1'b0};

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			civ_pkg::CIV_RUN: begin
				if (enter)
					nxt_state = civ_pkg::CIV_PUSH;
				else if (instr_done & return_from_handler)
					nxt_state = civ_pkg::CIV_POP;
				else if (instr_done & wait_exec)
					nxt_state = civ_pkg::CIV_WAIT;
				else if (instr_done & halt_exec)
					nxt_state = civ_pkg::CIV_HALT;
			end
			civ_pkg::CIV_PUSH:
				if (cnt_ff == civ_pkg::STACK_BYTES - 3'h1)
					nxt_state = civ_pkg::CIV_VEC;
			civ_pkg::CIV_VEC:  nxt_state = civ_pkg::CIV_RUN;
			civ_pkg::CIV_POP:
				if (cnt_ff == civ_pkg::STACK_BYTES)
					nxt_state = civ_pkg::CIV_RUN;
			civ_pkg::CIV_WAIT, civ_pkg::CIV_HALT: begin
				if (take_low)
					nxt_state = civ_pkg::CIV_PUSH;
				else if (low_wake)
					nxt_state = civ_pkg::CIV_RUN;
			end
			default: nxt_state = civ_pkg::CIV_RUN;
		endcase
	end

	// push order: pcl, pch, x, a, cc
	logic [7:0] push_byte;
	always_comb begin
		unique case (cnt_ff)
			3'h0: push_byte = pc_save_ff[7:0];
			3'h1: push_byte = pc_save_ff[15:8];
			3'h2: push_byte = x_save_ff;
			3'h3: push_byte = a_save_ff;
			default: push_byte = cc_save_ff;
		endcase
	end
	wire in_push = (state_ff == civ_pkg::CIV_PUSH);
	wire in_pop  = (state_ff == civ_pkg::CIV_POP);
	wire pop_rd  = in_pop & (cnt_ff < civ_pkg::STACK_BYTES);
	assign stack_we    = in_push;
	assign stack_re    = pop_rd;
	assign stack_addr  = in_pop ? sp_ff + 8'h01 : sp_ff;
	assign stack_wdata = push_byte;
	assign cpu_stall   = (state_ff != civ_pkg::CIV_RUN);
	assign wake        = low_wake;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= civ_pkg::CIV_RUN;
			cnt_ff   <= 3'h0;
			sp_ff    <= civ_pkg::SP_RESET;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= (in_push | pop_rd) ? cnt_ff + 3'h1 : 3'h0;
			if (in_push)
				sp_ff <= sp_ff - 8'h01;
			else if (pop_rd)
				sp_ff <= sp_ff + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_ff     <= 4'h0;
			trap_ff    <= 1'b0;
			pc_save_ff <= 16'h0000;
			x_save_ff  <= 8'h00;
			a_save_ff  <= 8'h00;
			cc_save_ff <= 8'h00;
		end else if (enter) begin
			vec_ff     <= sel_vec;
			trap_ff    <= take_trap;
			pc_save_ff <= cpu_pc;
			x_save_ff  <= cpu_x;
			a_save_ff  <= cpu_a;
			cc_save_ff <= condition_flags_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mask_flag <= 1'b1;
		else if (enter)
			mask_flag <= 1'b1;
		else if (in_pop & (cnt_ff == civ_pkg::STACK_BYTES))
			mask_flag <= 1'b0;
		else if (state_ff == civ_pkg::CIV_RUN & instr_done & ~cpu_stall)
			mask_flag <= condition_flags_reg[3];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sens_cfg <= civ_pkg::SENS_RESET;
		else if (sens_wr & mask_flag)
			sens_cfg <= sens_wdata;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			per_latch_ff <= 6'h00;
		else
			per_latch_ff <= per_flag | (per_latch_ff & ~per_flag_clear);
	end

	wire in_vec = (state_ff == civ_pkg::CIV_VEC);
	assign ext_ack = (in_vec & ~trap_ff & (vec_ff < civ_pkg::SRC_PER0)) ?
	                 4'(4'h1 << (vec_ff - civ_pkg::SRC_EXT0)) : 4'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_load  <= 1'b0;
			pc_value <= 16'h0000;
			ack_src  <= 10'h000;
			ret_pc_ff <= 16'h0000;
			restore_valid <= 1'b0;
			restore_x  <= 8'h00;
			restore_a  <= 8'h00;
			restore_cc <= 8'h00;
		end else begin
			pc_load       <= in_vec | (in_pop & cnt_ff == civ_pkg::STACK_BYTES);
			pc_value      <= in_vec ? vec_addr : ret_pc_ff;
			ack_src       <= (in_vec & ~trap_ff) ?
			                 10'(10'h001 << (vec_ff < civ_pkg::SRC_PER0 ?
			                 vec_ff - civ_pkg::SRC_EXT0 :
			                 vec_ff - civ_pkg::SRC_PER0 + 4'(civ_pkg::NUM_EXT))) : 10'h000;
			restore_valid <= in_pop & (cnt_ff == civ_pkg::STACK_BYTES);
			if (in_pop) begin
				unique case (cnt_ff)
					3'h0: restore_cc <= stack_rdata;
					3'h1: restore_a  <= stack_rdata;
					3'h2: restore_x  <= stack_rdata;
					3'h3: ret_pc_ff[15:8] <= stack_rdata;
					3'h4: ret_pc_ff[7:0]  <= stack_rdata;
					default: ;
				endcase
			end
		end
	end

	property p_entry_masks;
		@(posedge clk) disable iff (!rst_n) enter |=> mask_flag;
	endproperty
	a_entry_masks: assert property (p_entry_masks) else $error("mask not set on entry");
	property p_masked_no_irq;
		@(posedge clk) disable iff (!rst_n) mask_flag && !trap_exec |=> !$rose(in_push);
	endproperty
	a_masked_no_irq: assert property (p_masked_no_irq) else $error("irq taken masked");
	property p_five_pushes;
		@(posedge clk) disable iff (!rst_n)
			$rose(in_push) |-> in_push [*5] ##1 in_vec;
	endproperty
	a_five_pushes: assert property (p_five_pushes) else $error("push count wrong");
	property p_sp_down;
		@(posedge clk) disable iff (!rst_n) in_push |=> sp_ff == $past(sp_ff) - 8'h01;
	endproperty
	a_sp_down: assert property (p_sp_down) else $error("sp not decremented");
	property p_vec_load;
		@(posedge clk) disable iff (!rst_n) in_vec |=> pc_load && pc_value[15:8] == 8'hFF;
	endproperty
	a_vec_load: assert property (p_vec_load) else $error("vector not loaded");
	property p_ret_unmask;
		@(posedge clk) disable iff (!rst_n)
			$rose(in_pop) |-> ##6 !mask_flag;
	endproperty
	a_ret_unmask: assert property (p_ret_unmask) else $error("return kept mask");
	property p_trap_vec;
		@(posedge clk) disable iff (!rst_n)
			take_trap |-> ##7 pc_load && pc_value == civ_pkg::VEC_TRAP;
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
	property p_sens_gate;
		@(posedge clk) disable iff (!rst_n)
			!mask_flag |=> sens_cfg == $past(sens_cfg);
	endproperty
	a_sens_gate: assert property (p_sens_gate) else $error("sens written unmasked");
	c_trap:  cover property (@(posedge clk) take_trap);
	c_irq:   cover property (@(posedge clk) take_irq);
	c_halt:  cover property (@(posedge clk) wake_halt);
	c_ret:   cover property (@(posedge clk) restore_valid);
endmodule : civ_ctrl
`default_nettype wire

// ---- logic/civ_pkg.sv ----
// Summary of operation
// - maskable requests serviced only when mask clear
// - reset leaves global mask flag set
// - entry begins at instruction boundary, or on a wake from wait or halt
// - entry pushes pc, index, accumulator, flags
// - entry sets the global mask flag
// - pc loaded from selected two-byte vector
// - return restores context and clears mask
// - fixed priority: reset, trap, vectors 1-12
// - trap enters regardless of mask flag
// - external lines use vectors one to four
// - peripheral sources on vectors seven to twelve
// - any source wakes from wait
// - halt wake only by listed sources
// - edge latch cleared on handler entry
// - low combined pin blocks line request in rising-edge mode only
// - peripheral request needs enable and clear mask
// - clearing sequence discards latched request
// - entry uses five stack bytes, decrementing
// - two-bit sensitivity code per external line
// - sensitivity change drops pending; writes need mask
package civ_pkg;
	localparam int NUM_EXT = 4;
	localparam int NUM_PER = 6;
	localparam int NUM_SRC = 10;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
	localparam logic [15:0] VEC_BASE  = 16'hFFFA;
	localparam logic [3:0]  SRC_EXT0  = 4'h1;
	localparam logic [3:0]  SRC_PER0  = 4'h7;
	localparam logic [2:0]  STACK_BYTES = 3'h5;
	localparam logic [1:0]  SENS_FALL_LOW = 2'h0;
	localparam logic [1:0]  SENS_RISE     = 2'h1;
	localparam logic [1:0]  SENS_FALL     = 2'h2;
	localparam logic [1:0]  SENS_BOTH     = 2'h3;
	localparam logic [7:0]  SENS_RESET    = 8'h00;
	localparam logic [7:0]  SP_RESET      = 8'hFF;
	// halt-wake map over sources: ext0..3, avd, cmp, ovf, cap, rtc, spi
	localparam logic [9:0]  HALT_WAKE_MASK = 10'h34F;
	typedef enum logic [2:0] {
		CIV_RUN, CIV_PUSH, CIV_VEC, CIV_POP, CIV_WAIT, CIV_HALT
	} civ_state_t;
endpackage : civ_pkg

// ---- logic/civ_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module civ_sync (
	clk,
	rst_n,
	d,
	q
);
	input  wire logic clk;
	input  wire logic rst_n;
	input  wire logic d;
	output logic      q;
	logic stage1_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= 1'b1;
			q         <= 1'b1;
		end else begin
			stage1_ff <= d;
			q         <= stage1_ff;
		end
	end
endmodule : civ_sync
`default_nettype wire

// ---- logic/civ_ext_line.sv ----
`timescale 1ns/1ps
`default_nettype none
module civ_ext_line (
	clk,
	rst_n,
	pin_sync,
	sens,
	sens_change,
	ack,
	pending
);
	input  wire logic       clk;
	input  wire logic       rst_n;
	input  wire logic       pin_sync;
	input  wire logic [1:0] sens;
	input  wire logic       sens_change;
	input  wire logic       ack;
	output logic            pending;
	logic prev_ff;
	logic latch_ff;
	wire  rise = pin_sync & ~prev_ff;
	wire  fall = ~pin_sync & prev_ff;
	wire  edge_hit = (sens == civ_pkg::SENS_RISE) ? rise :
	                 (sens == civ_pkg::SENS_BOTH) ? (rise | fall) : fall;
	wire  level_hit = (sens == civ_pkg::SENS_FALL_LOW) & ~pin_sync;
	wire  blocked = ~pin_sync & (sens == civ_pkg::SENS_RISE);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff  <= 1'b1;
			latch_ff <= 1'b0;
		end else begin
			prev_ff <= pin_sync;
			if (edge_hit)
				latch_ff <= 1'b1;
			else if (ack | sens_change)
				latch_ff <= 1'b0;
		end
	end
	assign pending = (latch_ff | level_hit) & ~blocked;
endmodule : civ_ext_line
`default_nettype wire

// ---- dv/civ_stack_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module civ_stack_model (
	clk,
	stack_we,
	stack_re,
	stack_addr,
	stack_wdata,
	stack_rdata
);
	input  wire logic       clk;
	input  wire logic       stack_we;
	input  wire logic       stack_re;
	input  wire logic [7:0] stack_addr;
	input  wire logic [7:0] stack_wdata;
	output logic      [7:0] stack_rdata;
	logic [7:0] mem [256];
	logic [7:0] last_ff = 8'h5A;
	logic [7:0] wq [$];
	logic [7:0] wa [$];
	// unread stack shows inverted last byte
	assign stack_rdata = stack_re ? mem[stack_addr] : ~last_ff;
	always @(posedge clk) begin
		if (stack_we) begin
			mem[stack_addr] <= stack_wdata;
			wq.push_back(stack_wdata);
			wa.push_back(stack_addr);
		end
		if (stack_re) begin
			last_ff <= mem[stack_addr];
		end
	end
endmodule : civ_stack_model
`default_nettype wire

// ---- dv/cpu_interrupt_vectoring_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_vectoring_test;
	logic        clk, rst_n, instr_done, trap_exec, return_from_handler, wait_exec, halt_exec;
	logic        pin_irq_line_0, pin_irq_line_1, pin_irq_line_2, pin_irq_line_3, sens_wr;
	logic        mask_flag, stack_we, stack_re, pc_load, restore_valid, cpu_stall, wake;
	logic [5:0]  per_flag, per_enable, per_flag_clear;
	logic [7:0]  sens_wdata, cpu_x, cpu_a, condition_flags_reg, stack_rdata, sens_cfg;
	logic [7:0]  stack_addr, stack_wdata, restore_x, restore_a, restore_cc, sv_x, sv_a, sv_cc;
	logic [9:0]  ack_src;
	logic [15:0] cpu_pc, pc_value, sv_pc;
	int          n_fail, cmp_count, seq;

	civ_ctrl i_dut (
		.clk(clk), .rst_n(rst_n), .pin_irq_line_0(pin_irq_line_0),
		.pin_irq_line_1(pin_irq_line_1), .pin_irq_line_2(pin_irq_line_2),
		.pin_irq_line_3(pin_irq_line_3), .per_flag(per_flag), .per_enable(per_enable),
		.per_flag_clear(per_flag_clear), .sens_wr(sens_wr), .sens_wdata(sens_wdata),
		.instr_done(instr_done), .trap_exec(trap_exec),
		.return_from_handler(return_from_handler), .wait_exec(wait_exec),
		.halt_exec(halt_exec), .cpu_pc(cpu_pc), .cpu_x(cpu_x), .cpu_a(cpu_a),
		.condition_flags_reg(condition_flags_reg), .stack_rdata(stack_rdata),
		.mask_flag(mask_flag), .sens_cfg(sens_cfg), .stack_we(stack_we),
		.stack_re(stack_re), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
		.pc_load(pc_load), .pc_value(pc_value), .restore_valid(restore_valid),
		.restore_x(restore_x), .restore_a(restore_a), .restore_cc(restore_cc),
		.cpu_stall(cpu_stall), .wake(wake), .ack_src(ack_src)
	);
	civ_stack_model i_stk (
		.clk(clk), .stack_we(stack_we), .stack_re(stack_re), .stack_addr(stack_addr),
		.stack_wdata(stack_wdata), .stack_rdata(stack_rdata)
	);

	initial clk = 1'b0;
	always #25 clk = ~clk;

	task automatic tick();
		@(posedge clk);
		#2;
	endtask : tick

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : check

	task automatic stop_test();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (6) tick();
		rst_n = 1'b1;
		check(16'(mask_flag), 16'h1);
		check(16'(sens_cfg), 16'h0);
	endtask : do_reset

	// one instruction boundary, op = {trap, return, wait, halt}
	task automatic bnd(input logic [3:0] op, input logic [7:0] cc);
		{trap_exec, return_from_handler, wait_exec, halt_exec} = op;
		condition_flags_reg = cc;
		instr_done = 1'b1;
		tick();
		{trap_exec, return_from_handler, wait_exec, halt_exec} = 4'h0;
		instr_done = 1'b0;
	endtask : bnd

	task automatic pulse(input logic [5:0] set, input logic [5:0] clr);
		per_flag = set;
		per_flag_clear = clr;
		tick();
		per_flag = 6'h00;
		per_flag_clear = 6'h00;
	endtask : pulse

	task automatic wsens(input logic [7:0] d);
		sens_wdata = d;
		sens_wr = 1'b1;
		tick();
		sens_wr = 1'b0;
	endtask : wsens

	// s = {stall seen, wake seen} over ten cycles
	task automatic watch(output logic [1:0] s);
		s = 2'b00;
		repeat (10) begin
			s = s | {cpu_stall, wake};
			tick();
		end
	endtask : watch

	task automatic wait_load(output int n);
		n = 0;
		while (pc_load !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
	endtask : wait_load

	task automatic enter(input logic [3:0] op, input logic [7:0] cc, input logic [15:0] vec,
			input logic [9:0] ack);
		int n;
		seq++;
		cpu_pc = 16'h4A00 + 16'(seq * 37);
		cpu_x = 8'h3C ^ 8'(seq);
		cpu_a = 8'hC3 - 8'(seq);
		{sv_pc, sv_x, sv_a, sv_cc} = {cpu_pc, cpu_x, cpu_a, cc};
		i_stk.wq.delete();
		i_stk.wa.delete();
		bnd(op, cc);
		wait_load(n);
		check(16'(n), 16'h6);
		check(pc_value, vec);
		check(16'(ack_src), 16'(ack));
		check(16'(mask_flag), 16'h1);
		check({i_stk.wq[1], i_stk.wq[0]}, sv_pc);
		check({i_stk.wq[2], i_stk.wq[3]}, {sv_x, sv_a});
		check(16'(i_stk.wq[4]), 16'(sv_cc));
		for (int i = 1; i < 5; i++) begin
			check(16'(i_stk.wa[i]), 16'(i_stk.wa[0] - 8'(i)));
		end
	endtask : enter

	task automatic leave();
		int n;
		bnd(4'h4, sv_cc | 8'h08);
		wait_load(n);
		check(16'(n), 16'h6);
		check(16'(restore_valid), 16'h1);
		check({restore_x, restore_a}, {sv_x, sv_a});
		check(16'(restore_cc), 16'(sv_cc));
		check(pc_value, sv_pc);
		tick();
		check(16'(mask_flag), 16'h0);
	endtask : leave

	task automatic t_mask();
		logic [1:0] s;
		per_enable = 6'h01;
		pulse(6'h01, 6'h00);
		bnd(4'h0, 8'h08);
		watch(s);
		check(16'(s[1]), 16'h0);
		bnd(4'h0, 8'h00);
		check(16'(mask_flag), 16'h0);
		enter(4'h0, 8'h00, 16'hFFEC, 10'h010);
		pulse(6'h00, 6'h01);
		leave();
	endtask : t_mask

	task automatic t_prio();
		logic [1:0] s;
		per_enable = 6'h1F;
		bnd(4'h0, 8'h08);
		pulse(6'h02, 6'h00);
		enter(4'h8, 8'h08, 16'hFFFC, 10'h000);
		leave();
		pulse(6'h3F, 6'h00);
		for (int i = 0; i < 5; i++) begin
			enter(4'h0, 8'h00, 16'hFFEC - 16'(2 * i), 10'(16 << i));
			pulse(6'h00, 6'(1 << i));
			leave();
		end
		pulse(6'h00, 6'h20);
		per_enable = 6'h3F;
		bnd(4'h0, 8'h00);
		watch(s);
		check(16'(s[1]), 16'h0);
	endtask : t_prio

	task automatic t_ext();
		logic [1:0] s;
		wsens(8'hE4);
		check(16'(sens_cfg), 16'h0);
		bnd(4'h0, 8'h08);
		wsens(8'hE4);
		check(16'(sens_cfg), 16'hE4);
		{pin_irq_line_3, pin_irq_line_2, pin_irq_line_1, pin_irq_line_0} = 4'h0;
		repeat (4) tick();
		pin_irq_line_1 = 1'b1;
		repeat (4) tick();
		bnd(4'h0, 8'h00);
		for (int k = 0; k < 4; k++) begin
			enter(4'h0, 8'h00, 16'hFFF8 - 16'(2 * k), 10'(1 << k));
			pin_irq_line_0 = 1'b1;
			leave();
		end
		bnd(4'h0, 8'h00);
		watch(s);
		check(16'(s[1]), 16'h0);
	endtask : t_ext

	task automatic t_wake();
		logic [1:0] s;
		{pin_irq_line_3, pin_irq_line_2, pin_irq_line_1, pin_irq_line_0} = 4'hF;
		do_reset();
		per_enable = 6'h3F;
		bnd(4'h1, 8'h08);
		pulse(6'h0B, 6'h00);
		watch(s);
		check(16'(s[0]), 16'h0);
		pulse(6'h04, 6'h00);
		watch(s);
		check(16'(s[0]), 16'h1);
		do_reset();
		bnd(4'h2, 8'h08);
		pulse(6'h08, 6'h00);
		watch(s);
		check(16'(s[0]), 16'h1);
	endtask : t_wake

	initial begin
		{rst_n, instr_done, trap_exec, return_from_handler, wait_exec, halt_exec} = 6'h00;
		{pin_irq_line_3, pin_irq_line_2, pin_irq_line_1, pin_irq_line_0} = 4'hF;
		{per_flag, per_enable, per_flag_clear, sens_wr, sens_wdata} = 27'h0;
		{cpu_pc, cpu_x, cpu_a} = 32'h0;
		condition_flags_reg = 8'h08;
		{n_fail, cmp_count, seq} = 96'h0;
		do_reset();
		t_mask();
		t_prio();
		t_ext();
		t_wake();
		stop_test();
	end

	initial begin
		#(50 * 20000);
		n_fail++;
		stop_test();
	end
endmodule : cpu_interrupt_vectoring_test
`default_nettype wire
